// ---- design/flrb_defines.svh ----
// Offsets, codes, field positions, reset values and counts of the fault limit bank
`ifndef FLRB_DEFINES_SVH
`define FLRB_DEFINES_SVH

// Command codes seen on the link
`define FLRB_CMD_CLEAR_FAULTS 8'h03
`define FLRB_CMD_ALERT_MASK 8'h1b
`define FLRB_CMD_OV_RESP 8'h41
`define FLRB_CMD_UV_READBACK 8'h44
`define FLRB_CMD_UV_RESP 8'h45
`define FLRB_CMD_OC_LIMIT 8'h46
`define FLRB_CMD_OC_RESP 8'h47
`define FLRB_CMD_OC_WARN 8'h4a
`define FLRB_CMD_OT_LIMIT 8'h4f
`define FLRB_CMD_OT_RESP 8'h50
`define FLRB_CMD_OT_WARN 8'h51
`define FLRB_CMD_VIN_LIMIT 8'h55
`define FLRB_CMD_VIN_RESP 8'h56
`define FLRB_CMD_STATUS_BYTE 8'h78

// Response byte codes
`define FLRB_RESP_IGNORE 8'h00
`define FLRB_RESP_LATCH 8'h80

// Linear exponents in bits 15:11 of a limit word
`define FLRB_EXP_MSB 15
`define FLRB_EXP_LSB 11
`define FLRB_EXP_CURRENT 5'b11111
`define FLRB_EXP_TEMP 5'b11110
`define FLRB_EXP_VIN 5'b11101

// Summary status byte bit positions
`define FLRB_ST_OFF 6
`define FLRB_ST_VOUT_OV 5
`define FLRB_ST_IOUT_OC 4
`define FLRB_ST_TEMP 2
`define FLRB_ST_CML 1
`define FLRB_ST_OTHER 0

// Reset values
`define FLRB_RST_RESP 8'h80
`define FLRB_RST_LIMIT 10'h3ff
`define FLRB_RST_MASK 8'h00

// Scaling of the load-line product into readback LSBs
`define FLRB_DROOP_SHIFT 6

// Host register map on AXI4-Lite
`define FLRB_HOST_CMD 4'h0
`define FLRB_HOST_RESULT 4'h4
`define FLRB_HR_BUSY 16
`define FLRB_HR_ERR 17
`define FLRB_HR_ALERT 18
`define FLRB_HC_WRITE 8
`define FLRB_AXI_OKAY 2'b00
`define FLRB_AXI_SLVERR 2'b10

`endif

// ---- design/flrb_device.sv ----
// Device end: fault limits, response bytes, fault detection, alert and latch-off
`include "flrb_defines.svh"

// Notes on behaviour
// - Output overvoltage response is fixed latch code
// - Every fault sets status; only unmasked faults pull alert
// - Only ignore and latch codes exist
// - Ignore code keeps output running
// - Latch code shuts off until clear, re-enable
// - Undervoltage readback is target minus offset, droop
// - Host moves undervoltage threshold via offset
// - Overcurrent fault limit, 10 bits, exponent -1
// - Overcurrent warning limit, same format, separate
// - Overtemperature fault limit, quarter degrees, exponent -2
// - Overtemperature warning limit, same format, separate
// - Input overvoltage limit, 0.125 V, exponent -3
// - Own response byte for output undervoltage
// - Own response byte for output overcurrent
// - Own response byte for overtemperature
// - Own response byte for input overvoltage
// - Mask bit one stops condition pulling alert
// - Status bits: five OV, four OC, two temp
module flrb_device #(
  parameter int LIM_W = 10
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Link to host
  flrb_if.dev link,
  // Measurements and regulation inputs
  input wire logic regulation_enable_i,
  input wire logic [15:0] vout_target_i,
  input wire logic [15:0] undervoltage_margin_offset_i,
  input wire logic [7:0] load_line_slope_i,
  input wire logic [15:0] vout_meas_i,
  input wire logic vout_ov_detect_i,
  input wire logic [LIM_W-1:0] iout_meas_i,
  input wire logic [LIM_W-1:0] temp_meas_i,
  input wire logic [LIM_W-1:0] vin_meas_i,
  // Power stage and status
  output logic output_on_o,
  output logic [7:0] status_byte_o
);

  logic [7:0] uv_resp_reg;
  logic [7:0] oc_resp_reg;
  logic [7:0] ot_resp_reg;
  logic [7:0] vin_resp_reg;
  logic [LIM_W-1:0] oc_lim_reg;
  logic [LIM_W-1:0] ocw_lim_reg;
  logic [LIM_W-1:0] ot_lim_reg;
  logic [LIM_W-1:0] otw_lim_reg;
  logic [LIM_W-1:0] vin_lim_reg;
  logic [7:0] mask_reg;
  logic [7:0] sticky_reg;
  logic [7:0] sticky_next;
  logic [15:0] uv_thr_reg;
  flrb_pkg::flrb_pwr_t pwr_reg;
  flrb_pkg::flrb_pwr_t pwr_next;
  logic resp_valid_reg;
  logic [15:0] resp_rdata_reg;
  logic resp_err_reg;
  logic alert_oe_reg;
  logic output_on_reg;

  logic wr;
  logic rd;
  logic wr_err;
  logic clear_faults;
  logic [17:0] droop_prod;
  logic uv_flt;
  logic oc_flt;
  logic ocw_flt;
  logic ot_flt;
  logic otw_flt;
  logic vin_flt;
  logic latch_trip;
  logic [7:0] events;
  logic [15:0] rd_value;
  logic rd_known;

  // Linear word accepted only with the right exponent and an in-range mantissa
  function automatic logic lin_ok(input logic [15:0] w, input logic [4:0] e);
    lin_ok = (w[`FLRB_EXP_MSB:`FLRB_EXP_LSB] == e) && (w[`FLRB_EXP_LSB-1:LIM_W] == '0);
  endfunction

  function automatic logic resp_ok(input logic [15:0] w);
    resp_ok = (w[15:8] == 8'h00) &&
      ((w[7:0] == `FLRB_RESP_IGNORE) || (w[7:0] == `FLRB_RESP_LATCH));
  endfunction

  function automatic logic [15:0] lin_word(input logic [LIM_W-1:0] v, input logic [4:0] e);
    lin_word = {e, {(11 - LIM_W){1'b0}}, v};
  endfunction

  assign wr = ce_i && link.cmd_valid && link.cmd_write;
  assign rd = ce_i && link.cmd_valid && !link.cmd_write;
  assign clear_faults = wr && (link.cmd_code == `FLRB_CMD_CLEAR_FAULTS);

  // Write acceptance check per command
  always_comb
  begin
    wr_err = 1'b0;
    unique case (link.cmd_code)
      `FLRB_CMD_CLEAR_FAULTS, `FLRB_CMD_ALERT_MASK: wr_err = 1'b0;
      `FLRB_CMD_UV_RESP, `FLRB_CMD_OC_RESP, `FLRB_CMD_OT_RESP, `FLRB_CMD_VIN_RESP:
        wr_err = !resp_ok(link.cmd_wdata);
      `FLRB_CMD_OC_LIMIT, `FLRB_CMD_OC_WARN:
        wr_err = !lin_ok(link.cmd_wdata, `FLRB_EXP_CURRENT);
      `FLRB_CMD_OT_LIMIT, `FLRB_CMD_OT_WARN:
        wr_err = !lin_ok(link.cmd_wdata, `FLRB_EXP_TEMP);
      `FLRB_CMD_VIN_LIMIT: wr_err = !lin_ok(link.cmd_wdata, `FLRB_EXP_VIN);
      default: wr_err = 1'b1; // Read-only or unknown codes
    endcase
  end

  // Response bytes: only the two codes ever land
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      uv_resp_reg <= `FLRB_RST_RESP;
      oc_resp_reg <= `FLRB_RST_RESP;
      ot_resp_reg <= `FLRB_RST_RESP;
      vin_resp_reg <= `FLRB_RST_RESP;
    end
    else if (wr && !wr_err)
    begin
      if (link.cmd_code == `FLRB_CMD_UV_RESP) uv_resp_reg <= link.cmd_wdata[7:0];
      if (link.cmd_code == `FLRB_CMD_OC_RESP) oc_resp_reg <= link.cmd_wdata[7:0];
      if (link.cmd_code == `FLRB_CMD_OT_RESP) ot_resp_reg <= link.cmd_wdata[7:0];
      if (link.cmd_code == `FLRB_CMD_VIN_RESP) vin_resp_reg <= link.cmd_wdata[7:0];
    end
  end

  // Limit words and alert mask
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      oc_lim_reg <= `FLRB_RST_LIMIT;
      ocw_lim_reg <= `FLRB_RST_LIMIT;
      ot_lim_reg <= `FLRB_RST_LIMIT;
      otw_lim_reg <= `FLRB_RST_LIMIT;
      vin_lim_reg <= `FLRB_RST_LIMIT;
      mask_reg <= `FLRB_RST_MASK;
    end
    else if (wr && !wr_err)
    begin
      if (link.cmd_code == `FLRB_CMD_OC_LIMIT) oc_lim_reg <= link.cmd_wdata[LIM_W-1:0];
      if (link.cmd_code == `FLRB_CMD_OC_WARN) ocw_lim_reg <= link.cmd_wdata[LIM_W-1:0];
      if (link.cmd_code == `FLRB_CMD_OT_LIMIT) ot_lim_reg <= link.cmd_wdata[LIM_W-1:0];
      if (link.cmd_code == `FLRB_CMD_OT_WARN) otw_lim_reg <= link.cmd_wdata[LIM_W-1:0];
      if (link.cmd_code == `FLRB_CMD_VIN_LIMIT) vin_lim_reg <= link.cmd_wdata[LIM_W-1:0];
      if (link.cmd_code == `FLRB_CMD_ALERT_MASK) mask_reg <= link.cmd_wdata[7:0];
    end
  end

  // Undervoltage threshold follows target, margin offset and load line
  assign droop_prod = load_line_slope_i * {8'h00, iout_meas_i[LIM_W-1:0]};
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      uv_thr_reg <= 16'h0000;
    else if (ce_i)
      uv_thr_reg <= 16'(vout_target_i - undervoltage_margin_offset_i -
        16'(droop_prod >> `FLRB_DROOP_SHIFT));
  end

  // Fault and warning detection; warnings never trip the output
  assign uv_flt = regulation_enable_i && (vout_meas_i < uv_thr_reg);
  assign oc_flt = iout_meas_i > oc_lim_reg;
  assign ocw_flt = iout_meas_i > ocw_lim_reg;
  assign ot_flt = temp_meas_i > ot_lim_reg;
  assign otw_flt = temp_meas_i > otw_lim_reg;
  assign vin_flt = vin_meas_i > vin_lim_reg;

  // Overvoltage always latches; others latch only with the latch code
  assign latch_trip = vout_ov_detect_i ||
    (uv_flt && (uv_resp_reg == `FLRB_RESP_LATCH)) ||
    (oc_flt && (oc_resp_reg == `FLRB_RESP_LATCH)) ||
    (ot_flt && (ot_resp_reg == `FLRB_RESP_LATCH)) ||
    (vin_flt && (vin_resp_reg == `FLRB_RESP_LATCH));

  always_comb
  begin
    events = 8'h00;
    events[`FLRB_ST_VOUT_OV] = vout_ov_detect_i;
    events[`FLRB_ST_IOUT_OC] = oc_flt;
    events[`FLRB_ST_TEMP] = ot_flt || otw_flt;
    events[`FLRB_ST_OTHER] = uv_flt || vin_flt || ocw_flt;
    events[`FLRB_ST_CML] = wr && wr_err;
    // A new event wins over a clear in the same cycle
    sticky_next = (clear_faults ? 8'h00 : sticky_reg) | events;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      sticky_reg <= 8'h00;
    else if (ce_i)
      sticky_reg <= sticky_next;
  end

  // Output power state: off after a latching fault until clear and re-enable
  always_comb
  begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      flrb_pkg::FLRB_RUN: if (latch_trip) pwr_next = flrb_pkg::FLRB_OFF;
      flrb_pkg::FLRB_OFF: if (clear_faults && !latch_trip) pwr_next = flrb_pkg::FLRB_REARM;
      flrb_pkg::FLRB_REARM:
        if (latch_trip) pwr_next = flrb_pkg::FLRB_OFF;
        else if (!regulation_enable_i) pwr_next = flrb_pkg::FLRB_RUN;
      default: pwr_next = flrb_pkg::FLRB_OFF;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      pwr_reg <= flrb_pkg::FLRB_RUN;
    else if (ce_i)
      pwr_reg <= pwr_next;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      output_on_reg <= 1'b0;
    else if (ce_i)
      output_on_reg <= regulation_enable_i && (pwr_next == flrb_pkg::FLRB_RUN);
  end

  // Alert pulled low while any unmasked fault bit stands
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      alert_oe_reg <= 1'b0;
    else if (ce_i)
      alert_oe_reg <= |(sticky_next & ~mask_reg & ~(8'h01 << `FLRB_ST_OFF));
  end

  // Readback mux
  always_comb
  begin
    rd_value = 16'h0000;
    rd_known = 1'b1;
    unique case (link.cmd_code)
      `FLRB_CMD_ALERT_MASK: rd_value = {8'h00, mask_reg};
      `FLRB_CMD_OV_RESP: rd_value = {8'h00, `FLRB_RESP_LATCH};
      `FLRB_CMD_UV_READBACK: rd_value = uv_thr_reg;
      `FLRB_CMD_UV_RESP: rd_value = {8'h00, uv_resp_reg};
      `FLRB_CMD_OC_LIMIT: rd_value = lin_word(oc_lim_reg, `FLRB_EXP_CURRENT);
      `FLRB_CMD_OC_RESP: rd_value = {8'h00, oc_resp_reg};
      `FLRB_CMD_OC_WARN: rd_value = lin_word(ocw_lim_reg, `FLRB_EXP_CURRENT);
      `FLRB_CMD_OT_LIMIT: rd_value = lin_word(ot_lim_reg, `FLRB_EXP_TEMP);
      `FLRB_CMD_OT_RESP: rd_value = {8'h00, ot_resp_reg};
      `FLRB_CMD_OT_WARN: rd_value = lin_word(otw_lim_reg, `FLRB_EXP_TEMP);
      `FLRB_CMD_VIN_LIMIT: rd_value = lin_word(vin_lim_reg, `FLRB_EXP_VIN);
      `FLRB_CMD_VIN_RESP: rd_value = {8'h00, vin_resp_reg};
      `FLRB_CMD_STATUS_BYTE: rd_value = {8'h00, status_byte_o};
      default: rd_known = 1'b0;
    endcase
  end

  // One answer per command, one cycle after it is taken
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      resp_valid_reg <= 1'b0;
      resp_rdata_reg <= 16'h0000;
      resp_err_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      resp_valid_reg <= link.cmd_valid;
      resp_rdata_reg <= rd ? rd_value : 16'h0000;
      resp_err_reg <= link.cmd_valid && (rd ? !rd_known : wr_err);
    end
  end

  assign link.resp_valid = resp_valid_reg;
  assign link.resp_rdata = resp_rdata_reg;
  assign link.resp_err = resp_err_reg;
  assign link.alert_line_o = 1'b0;
  assign link.alert_line_oe = alert_oe_reg;
  assign output_on_o = output_on_reg;
  assign status_byte_o = sticky_reg | {1'b0, !output_on_reg, 6'h00};

endmodule // flrb_device

// ---- design/flrb_host.sv ----
// Host end: AXI4-Lite command and result registers driving the command link
`include "flrb_defines.svh"

module flrb_host (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Link to device
  flrb_if.host link,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] cmd_reg;
  logic busy_reg;
  logic err_reg;
  logic [15:0] result_reg;
  logic cmd_valid_reg;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic aw_have;
  logic w_have;
  logic do_wr;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic start;
  logic aw_held_next;
  logic w_held_next;
  logic bvalid_next;
  logic rvalid_next;

  assign aw_hs = s_axi_awvalid_i && awready_reg;
  assign w_hs = s_axi_wvalid_i && wready_reg;
  assign ar_hs = s_axi_arvalid_i && arready_reg;
  assign aw_have = aw_held_reg || aw_hs;
  assign w_have = w_held_reg || w_hs;
  assign do_wr = ce_i && aw_have && w_have;
  assign wr_addr = aw_hs ? s_axi_awaddr_i : awaddr_reg;
  assign wr_data = w_hs ? s_axi_wdata_i : wdata_reg;
  assign wr_strb = w_hs ? s_axi_wstrb_i : wstrb_reg;
  // Command only on a full-word write to the command register while idle
  assign start = do_wr && (wr_addr == `FLRB_HOST_CMD) && (wr_strb == 4'hf) && !busy_reg;
  assign aw_held_next = aw_have && !do_wr;
  assign w_held_next = w_have && !do_wr;
  assign bvalid_next = do_wr || (bvalid_reg && !s_axi_bready_i);
  assign rvalid_next = (ce_i && ar_hs) || (rvalid_reg && !s_axi_rready_i);

  // Write channels: address and data taken in either order, then one response
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `FLRB_AXI_OKAY;
    end
    else if (ce_i)
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready_reg <= !aw_held_next && !bvalid_next;
      wready_reg <= !w_held_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      if (aw_hs)
        awaddr_reg <= s_axi_awaddr_i;
      if (w_hs)
      begin
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (do_wr)
        bresp_reg <= start ? `FLRB_AXI_OKAY : `FLRB_AXI_SLVERR;
    end
  end

  // Read channel
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `FLRB_AXI_OKAY;
    end
    else if (ce_i)
    begin
      rvalid_reg <= rvalid_next;
      arready_reg <= !rvalid_next;
      if (ar_hs)
      begin
        rresp_reg <= `FLRB_AXI_OKAY;
        unique case (s_axi_araddr_i)
          `FLRB_HOST_CMD: rdata_reg <= cmd_reg;
          `FLRB_HOST_RESULT: rdata_reg <= {13'h0000, !link.alert_line, err_reg, busy_reg,
            result_reg};
          default:
          begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `FLRB_AXI_SLVERR;
          end
        endcase
      end
    end
  end

  // Command issue and result capture; any command word is sent as written, unchecked
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      cmd_reg <= 32'h0000_0000;
      cmd_valid_reg <= 1'b0;
      busy_reg <= 1'b0;
      err_reg <= 1'b0;
      result_reg <= 16'h0000;
    end
    else if (ce_i)
    begin
      cmd_valid_reg <= start;
      if (start)
      begin
        cmd_reg <= wr_data;
        busy_reg <= 1'b1;
      end
      else if (link.resp_valid && busy_reg)
      begin
        busy_reg <= 1'b0;
        err_reg <= link.resp_err;
        result_reg <= link.resp_rdata;
      end
    end
  end

  assign link.cmd_valid = cmd_valid_reg;
  assign link.cmd_write = cmd_reg[`FLRB_HC_WRITE];
  assign link.cmd_code = cmd_reg[7:0];
  assign link.cmd_wdata = cmd_reg[31:16];
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

endmodule // flrb_host

// ---- design/flrb_if.sv ----
// Command link and alert line between the management host and the fault limit bank
interface flrb_if;
  logic cmd_valid;
  logic cmd_write;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata;
  logic resp_valid;
  logic [15:0] resp_rdata;
  logic resp_err;
  logic alert_line_o;
  logic alert_line_oe;
  logic alert_line;

  // Open-drain alert with pull-up
  assign alert_line = alert_line_oe ? alert_line_o : 1'b1;

  modport dev (
    input cmd_valid,
    input cmd_write,
    input cmd_code,
    input cmd_wdata,
    output resp_valid,
    output resp_rdata,
    output resp_err,
    output alert_line_o,
    output alert_line_oe
  );

  modport host (
    output cmd_valid,
    output cmd_write,
    output cmd_code,
    output cmd_wdata,
    input resp_valid,
    input resp_rdata,
    input resp_err,
    input alert_line
  );
endinterface

// ---- design/flrb_pkg.sv ----
// Types used by the device end of the fault limit bank link
package flrb_pkg;

  typedef enum logic [1:0] {
    FLRB_RUN = 2'b00,
    FLRB_OFF = 2'b01,
    FLRB_REARM = 2'b11
  } flrb_pwr_t;

endpackage

// ---- verification/flrb_chk.sv ----
// Concurrent checks on the command link of the fault limit bank
module flrb_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Command link
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic resp_valid,
  input wire logic [15:0] resp_rdata,
  input wire logic resp_err
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic wr;
  logic [4:0] ex;
  assign wr = cmd_valid && cmd_write;
  assign ex = cmd_wdata[15:11];

  a_answer_next: assert property (cmd_valid |=> resp_valid)
    else $error("no answer one cycle after command");
  a_answer_caused: assert property (resp_valid |-> $past(cmd_valid))
    else $error("answer without command");
  a_ov_write_refused: assert property (wr && cmd_code == 8'h41 |=> resp_err)
    else $error("overvoltage response write taken");
  a_ov_read_latch: assert property (cmd_valid && !cmd_write && cmd_code == 8'h41
    |=> resp_rdata == 16'h0080 && !resp_err)
    else $error("overvoltage response not latch code");
  a_resp_code_gate: assert property (wr && cmd_code inside {8'h45, 8'h47, 8'h50, 8'h56}
    |=> resp_err == !($past(cmd_wdata) inside {16'h0000, 16'h0080}))
    else $error("response code gate wrong");
  a_oc_exp_gate: assert property (wr && cmd_code inside {8'h46, 8'h4a}
    |=> resp_err == ($past(ex) != 5'h1f || $past(cmd_wdata[10])))
    else $error("current exponent gate wrong");
  a_ot_exp_gate: assert property (wr && cmd_code inside {8'h4f, 8'h51}
    |=> resp_err == ($past(ex) != 5'h1e || $past(cmd_wdata[10])))
    else $error("temperature exponent gate wrong");
  a_vin_exp_gate: assert property (wr && cmd_code == 8'h55
    |=> resp_err == ($past(ex) != 5'h1d || $past(cmd_wdata[10])))
    else $error("input voltage exponent gate wrong");
  a_uv_read_only: assert property (wr && cmd_code == 8'h44 |=> resp_err)
    else $error("threshold readback write taken");

  c_resp_write: cover property (wr && cmd_code == 8'h47);
  c_refused: cover property (resp_valid && resp_err);
  c_uv_read: cover property (cmd_valid && !cmd_write && cmd_code == 8'h44);
endmodule // flrb_chk

// ---- verification/flrb_tb.sv ----
// Bench joining host and device ends of the fault limit bank
module flrb_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, reset_n_i, ce_i;
  logic [3:0] s_axi_awaddr_i, s_axi_wstrb_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i;
  logic regulation_enable_i, vout_ov_detect_i, output_on_o;
  logic [15:0] vout_target_i, undervoltage_margin_offset_i, vout_meas_i;
  logic [7:0] load_line_slope_i, status_byte_o;
  logic [9:0] iout_meas_i, temp_meas_i, vin_meas_i;
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] rc [10] = '{8'h41, 8'h45, 8'h47, 8'h50, 8'h56, 8'h46, 8'h4a, 8'h4f, 8'h51, 8'h55};
  logic [4:0] re [10] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h1f, 5'h1f, 5'h1e, 5'h1e, 5'h1d};

  flrb_if link_if ();
  flrb_host flrb_host_inst (.mclk_i, .reset_n_i, .ce_i, .link(link_if), .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i);
  flrb_device #(.LIM_W(10)) flrb_device_inst (.mclk_i, .reset_n_i, .ce_i, .link(link_if),
    .regulation_enable_i, .vout_target_i, .undervoltage_margin_offset_i, .load_line_slope_i,
    .vout_meas_i, .vout_ov_detect_i, .iout_meas_i, .temp_meas_i, .vin_meas_i, .output_on_o,
    .status_byte_o);
  flrb_chk flrb_chk_inst (.mclk_i, .reset_n_i, .cmd_valid(link_if.cmd_valid),
    .cmd_write(link_if.cmd_write), .cmd_code(link_if.cmd_code),
    .cmd_wdata(link_if.cmd_wdata), .resp_valid(link_if.resp_valid),
    .resp_rdata(link_if.resp_rdata), .resp_err(link_if.resp_err));

  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    while (!done)
    begin
      @(posedge mclk_i);
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
      done = s_axi_bvalid_o;
      r = s_axi_bresp_o;
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    while (!done)
    begin
      @(posedge mclk_i);
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
      done = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
    end
  endtask

  // Issue one link command and poll until the result is stored
  task automatic cmd(input logic [7:0] c, input logic w, input logic [15:0] d,
    output logic [31:0] res);
    logic [1:0] r;
    axi_wr(4'h0, {d, 7'h00, w, c}, r);
    chk(32'(r), 32'h0);
    res = 32'h0001_0000;
    while (res[16])
      axi_rd(4'h4, res, r);
  endtask

  // Expected value holds the error flag in bit 16
  task automatic rw(input logic [7:0] c, input logic w, input logic [15:0] d,
    input logic [16:0] e);
    logic [31:0] res;
    cmd(c, w, d, res);
    chk({15'h0, res[17], res[15:0]}, {15'h0, e});
  endtask

  task automatic look(input logic on, input logic [7:0] st, input logic al);
    repeat (3) @(posedge mclk_i);
    chk(32'(output_on_o), 32'(on));
    chk(32'(status_byte_o), 32'(st));
    chk(32'(link_if.alert_line), 32'(al));
  endtask

  function automatic logic [9:0] lim(input int i);
    return 10'(12'h250 - 16 * i);
  endfunction

  task automatic rearm;
    logic [31:0] res;
    iout_meas_i <= 10'h010;
    temp_meas_i <= 10'h000;
    vin_meas_i <= 10'h000;
    vout_ov_detect_i <= 1'b0;
    vout_meas_i <= 16'h0100;
    cmd(8'h03, 1'b1, 16'h0000, res);
    look(1'b0, 8'h40, 1'b1);
    regulation_enable_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    regulation_enable_i <= 1'b1;
    look(1'b1, 8'h00, 1'b1);
  endtask

  task automatic t_reset;
    chk(32'(status_byte_o), 32'h40);
    regulation_enable_i <= 1'b1;
    @(posedge mclk_i);
    for (int i = 0; i < 10; i++)
      rw(rc[i], 1'b0, 16'h0, (i < 5) ? 17'h00080 : {1'b0, re[i], 1'b0, 10'h3ff});
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(4'h8, d, r);
    chk(32'(r), 32'h2);
    axi_wr(4'h4, 32'h0000_0000, r);
    chk(32'(r), 32'h2);
    for (int i = 1; i < 5; i++)
    begin
      rw(rc[i], 1'b1, 16'h0000, 17'h0);
      rw(rc[i], 1'b0, 16'h0000, 17'h0);
      rw(rc[i], 1'b1, 16'h00c0, 17'h10000);
      rw(rc[i], 1'b0, 16'h0000, 17'h0);
      rw(rc[i], 1'b1, 16'h0080, 17'h0);
    end
    for (int i = 5; i < 10; i++)
    begin
      rw(rc[i], 1'b1, {re[i], 1'b0, lim(i)}, 17'h0);
      rw(rc[i], 1'b1, {re[i] ^ 5'h01, 1'b0, 10'h003}, 17'h10000);
      rw(rc[i], 1'b0, 16'h0000, {1'b0, re[i], 1'b0, lim(i)});
    end
    rw(8'h41, 1'b1, 16'h0000, 17'h10000);
    rw(8'h44, 1'b1, 16'h0000, 17'h10000);
    rw(8'h44, 1'b0, 16'h0000, 17'h000ee);
  endtask

  task automatic t_faults;
    rw(8'h03, 1'b1, 16'h0000, 17'h0);
    look(1'b1, 8'h00, 1'b1);
    rw(8'h46, 1'b1, {5'h1f, 1'b0, 10'h020}, 17'h0);
    rw(8'h47, 1'b1, 16'h0000, 17'h0);
    iout_meas_i <= 10'h021;
    look(1'b1, 8'h10, 1'b0);
    rw(8'h1b, 1'b1, 16'h0010, 17'h0);
    rw(8'h03, 1'b1, 16'h0000, 17'h0);
    look(1'b1, 8'h10, 1'b1);
    rw(8'h1b, 1'b1, 16'h0000, 17'h0);
    rw(8'h47, 1'b1, 16'h0080, 17'h0);
    look(1'b0, 8'h50, 1'b0);
    rw(8'h78, 1'b0, 16'h0000, 17'h00050);
    rearm();
    vout_ov_detect_i <= 1'b1;
    look(1'b0, 8'h60, 1'b0);
    rearm();
    temp_meas_i <= 10'h1d1;
    look(1'b1, 8'h04, 1'b0);
    temp_meas_i <= 10'h1e1;
    look(1'b0, 8'h44, 1'b0);
    rearm();
    vin_meas_i <= 10'h1c1;
    look(1'b0, 8'h41, 1'b0);
    rearm();
    vout_meas_i <= 16'h00e0;
    look(1'b0, 8'h41, 1'b0);
    rearm();
  endtask

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    s_axi_awaddr_i = 4'h0;
    s_axi_araddr_i = 4'h0;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hf;
    s_axi_awvalid_i = 1'b0;
    s_axi_wvalid_i = 1'b0;
    s_axi_arvalid_i = 1'b0;
    s_axi_bready_i = 1'b1;
    s_axi_rready_i = 1'b1;
    regulation_enable_i = 1'b0;
    vout_target_i = 16'h0100;
    undervoltage_margin_offset_i = 16'h0010;
    load_line_slope_i = 8'h08;
    vout_meas_i = 16'h0100;
    vout_ov_detect_i = 1'b0;
    iout_meas_i = 10'h010;
    temp_meas_i = 10'h000;
    vin_meas_i = 10'h000;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_regs();
    t_faults();
    final_report();
  end
endmodule // flrb_tb
